//--- rtl/csri_top.sv
// Behaviour
// - Master source: 00 slow, 01 main, 11 PLL
// - Master prescaler divides by 1 to 64
// - Each output clock has same source encoding
// - Each output clock has power-of-two prescaler
// - Enable register write sets mask bits
// - Disable register write clears mask bits
// - Status bit 0 shows oscillator stable
// - Status bit 2 shows PLL locked
// - Status bit 3 shows master clock ready
// - Status bits 8-10 show output clocks ready
// - Mask register reads current enable state
// - Oscillator stable after programmed start-up time
// - PLL lock after programmed slow cycles
`timescale 1ns/1ps
`include "csri_params.svh"

// Clock divider fed by synchronised source levels and rising-edge pulses
module csri_clkdiv (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // Configuration and sources
  input wire csri_pkg::csri_clk_cfg_t cfg_in,
  input wire logic [2:0] lvl_in,
  input wire logic [2:0] rise_in,
  // Divided clock
  output logic clk_out
);
  import csri_pkg::*;

  logic [4:0] cnt_r;
  logic [4:0] half;
  logic [1:0] idx;
  logic ok;

  // Map source code to input index; reserved codes select nothing
  always_comb begin
    idx = 2'h0;
    ok = 1'b1;
    half = 5'h0;
    case (cfg_in.clock_source_select)
      2'h0: idx = 2'h0;
      2'h1: idx = 2'h1;
      2'h3: idx = 2'h2;
      default: ok = 1'b0;
    endcase
    if (cfg_in.prescaler_select == `CSRI_DIV_RSVD) begin
      ok = 1'b0;
    end
    if (cfg_in.prescaler_select != 3'h0) begin
      half = 5'((6'h1 << (cfg_in.prescaler_select - 3'h1)) - 6'h1);
    end
  end

  // Toggle every 2^(n-1) source edges; divide by one follows the level
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_r <= 5'h0;
      clk_out <= 1'b0;
    end else if (!ok) begin
      cnt_r <= 5'h0; // Reserved setting parks the output
    end else if (cfg_in.prescaler_select == 3'h0) begin
      clk_out <= lvl_in[idx];
      cnt_r <= 5'h0;
    end else if (rise_in[idx]) begin
      if (cnt_r >= half) begin
        cnt_r <= 5'h0;
        clk_out <= ~clk_out;
      end else begin
        cnt_r <= cnt_r + 5'h1;
      end
    end
  end
endmodule

module csri_top #(
  parameter int SETTLE_CYC = `CSRI_SETTLE_CYC
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // Register port
  input wire csri_pkg::csri_bus_req_t bus_in,
  output logic [31:0] rdata_out,
  // Source clocks: 0 slow, 1 main, 2 PLL
  input wire logic [2:0] src_clk_in,
  // Generated clocks
  output logic mck_out,
  output logic [2:0] prog_clk_out,
  // Interrupt
  output logic irq_out
);
  import csri_pkg::*;

  typedef enum logic [1:0] {OSC_OFF, OSC_WAIT, OSC_STABLE} csri_osc_t;

  logic [2:0] s1_r, s2_r, s3_r, lvl_r;
  logic [2:0] rise;
  csri_clk_cfg_t cfg_r [4];
  logic [3:0] rdy_r;
  logic [7:0] settle_r [4];
  logic [10:0] mask_r, event_r, flags, flags_d_r;
  logic [31:0] rdata_nxt;
  logic [9:0] osc_ctl_r;
  logic [10:0] osc_cnt_r;
  csri_osc_t osc_st_r;
  logic [5:0] pll_cnt_cfg_r, pll_cnt_r;
  logic lock_r, pll_arm_r;
  logic [3:0] clk_q;
  logic wr_osc, wr_pll;

  // Three-stage synchronisers; a level counts once stages two and three agree
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      s3_r <= 3'h0;
      lvl_r <= 3'h0;
    end else begin
      s1_r <= src_clk_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < 3; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          lvl_r[i] <= s3_r[i];
        end
      end
    end
  end

  // One-cycle pulse on each accepted rising edge
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      rise[i] = (s2_r[i] == s3_r[i]) && s3_r[i] && !lvl_r[i];
    end
  end

  assign wr_osc = bus_in.wr && (bus_in.addr == `CSRI_OFF_OSC_CFG);
  assign wr_pll = bus_in.wr && (bus_in.addr == `CSRI_OFF_PLL_CFG);

  // Clock configs and ready tracking; index 0 is the master clock
  for (genvar g = 0; g < 4; g++) begin : g_clk
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        cfg_r[g] <= '0;
        settle_r[g] <= 8'h0;
        rdy_r[g] <= 1'b1;
      end else if (bus_in.wr && (bus_in.addr == 8'(`CSRI_OFF_MCK_CFG + 4 * g))) begin
        cfg_r[g] <= bus_in.wdata[4:0];
        settle_r[g] <= 8'(SETTLE_CYC);
        rdy_r[g] <= 1'b0;
      end else if (settle_r[g] != 8'h0) begin
        settle_r[g] <= settle_r[g] - 8'h1;
      end else begin
        // A reserved code never reports ready
        rdy_r[g] <= (cfg_r[g].clock_source_select != `CSRI_SRC_RSVD) &&
                    (cfg_r[g].prescaler_select != `CSRI_DIV_RSVD);
      end
    end

    csri_clkdiv u_div (
      .mclk_in(mclk_in),
      .arst_n_in(arst_n_in),
      .cfg_in(cfg_r[g]),
      .lvl_in(lvl_r),
      .rise_in(rise),
      .clk_out(clk_q[g])
    );
  end

  // Registered clock outputs keep every output straight from a flop
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mck_out <= 1'b0;
      prog_clk_out <= 3'h0;
    end else begin
      mck_out <= clk_q[0];
      prog_clk_out <= clk_q[3:1];
    end
  end

  // Oscillator start-up: stable after eight slow cycles per count unit
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      osc_ctl_r <= 10'h0;
      osc_cnt_r <= 11'h0;
      osc_st_r <= OSC_OFF;
    end else if (wr_osc) begin
      osc_ctl_r <= {bus_in.wdata[15:8], bus_in.wdata[1:0]};
      osc_cnt_r <= 11'h0;
      if (bus_in.wdata[`CSRI_OSC_BYP_BIT]) begin
        osc_st_r <= OSC_STABLE;
      end else if (!bus_in.wdata[`CSRI_OSC_EN_BIT]) begin
        osc_st_r <= OSC_OFF;
      end else if (osc_st_r == OSC_OFF) begin
        osc_st_r <= OSC_WAIT;
      end
    end else begin
      case (osc_st_r)
        OSC_WAIT: begin
          if (osc_cnt_r >= {osc_ctl_r[9:2], 3'h0}) begin
            osc_st_r <= OSC_STABLE;
          end else if (rise[0]) begin
            osc_cnt_r <= osc_cnt_r + 11'h1;
          end
        end
        OSC_OFF, OSC_STABLE: osc_cnt_r <= 11'h0;
        default: osc_st_r <= OSC_OFF;
      endcase
    end
  end

  // PLL lock after the programmed slow cycles following a config write
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pll_cnt_cfg_r <= 6'h0;
      pll_cnt_r <= 6'h0;
      pll_arm_r <= 1'b0;
      lock_r <= 1'b0;
    end else if (wr_pll) begin
      pll_cnt_cfg_r <= bus_in.wdata[13:8];
      pll_cnt_r <= 6'h0;
      pll_arm_r <= 1'b1; // Only a config write may start the count
      lock_r <= 1'b0;
    end else if (pll_arm_r) begin
      if (pll_cnt_r >= pll_cnt_cfg_r) begin
        lock_r <= 1'b1;
        pll_arm_r <= 1'b0;
      end else if (rise[0]) begin
        pll_cnt_r <= pll_cnt_r + 6'h1;
      end
    end
  end

  // Live flag levels in status layout
  always_comb begin
    flags = 11'h0;
    flags[`CSRI_BIT_MOSC] = (osc_st_r == OSC_STABLE);
    flags[`CSRI_BIT_LOCK] = lock_r;
    flags[`CSRI_BIT_MCK] = rdy_r[0];
    flags[10:8] = rdy_r[3:1];
  end

  // Mask set and clear; the set offset is checked first, so one write never does both
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mask_r <= 11'h0;
    end else if (bus_in.wr && bus_in.addr == `CSRI_OFF_INT_SET) begin
      mask_r <= mask_r | (bus_in.wdata[10:0] & `CSRI_FLAG_MASK);
    end else if (bus_in.wr && bus_in.addr == `CSRI_OFF_INT_CLR) begin
      mask_r <= mask_r & ~bus_in.wdata[10:0];
    end
  end

  // Sticky rising-edge events, write one to clear; a new edge wins
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flags_d_r <= `CSRI_FLAG_RST; // Same as the live flags, so no false edge follows reset
      event_r <= 11'h0;
    end else begin
      flags_d_r <= flags;
      if (bus_in.wr && bus_in.addr == `CSRI_OFF_EVENT) begin
        event_r <= (event_r & ~bus_in.wdata[10:0]) | (flags & ~flags_d_r);
      end else begin
        event_r <= event_r | (flags & ~flags_d_r);
      end
    end
  end

  // Interrupt level: a live flag or a sticky event under an open mask
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |((flags | event_r) & mask_r);
    end
  end

  // Read mux; write-only and unmapped offsets read as zero
  always_comb begin
    rdata_nxt = 32'h0;
    case (bus_in.addr)
      `CSRI_OFF_MCK_CFG: rdata_nxt = {27'h0, cfg_r[0]};
      `CSRI_OFF_PCK0_CFG: rdata_nxt = {27'h0, cfg_r[1]};
      `CSRI_OFF_PCK1_CFG: rdata_nxt = {27'h0, cfg_r[2]};
      `CSRI_OFF_PCK2_CFG: rdata_nxt = {27'h0, cfg_r[3]};
      `CSRI_OFF_STATUS: rdata_nxt = {21'h0, flags};
      `CSRI_OFF_INT_MASK: rdata_nxt = {21'h0, mask_r};
      `CSRI_OFF_EVENT: rdata_nxt = {21'h0, event_r};
      `CSRI_OFF_OSC_CFG: rdata_nxt = {16'h0, osc_ctl_r[9:2], 6'h0, osc_ctl_r[1:0]};
      `CSRI_OFF_PLL_CFG: rdata_nxt = {18'h0, pll_cnt_cfg_r, 8'h0};
      default: rdata_nxt = 32'h0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= 32'h0;
    end else begin
      rdata_out <= bus_in.rd ? rdata_nxt : 32'h0;
    end
  end

  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  chk_irq_level: assert property (
    |(flags & mask_r) |=> irq_out)
    else $error("irq low although an enabled flag is set");
  chk_mask_set: assert property (
    bus_in.wr && bus_in.addr == `CSRI_OFF_INT_SET && bus_in.wdata[`CSRI_BIT_MCK] |=> mask_r[`CSRI_BIT_MCK])
    else $error("enable write did not set mask");
  chk_mask_clear: assert property (
    bus_in.wr && bus_in.addr == `CSRI_OFF_INT_CLR && bus_in.wdata[`CSRI_BIT_LOCK] |=> !mask_r[`CSRI_BIT_LOCK])
    else $error("disable write did not clear mask");
  chk_mask_read: assert property (
    bus_in.rd && bus_in.addr == `CSRI_OFF_INT_MASK |=> rdata_out == {21'h0, $past(mask_r)})
    else $error("mask read mismatch");
  chk_status_read: assert property (
    bus_in.rd && bus_in.addr == `CSRI_OFF_STATUS |=> rdata_out[10:8] == $past(rdy_r[3:1]))
    else $error("status read mismatch");
  chk_mck_not_ready: assert property (
    bus_in.wr && bus_in.addr == `CSRI_OFF_MCK_CFG |=> !flags[`CSRI_BIT_MCK])
    else $error("master ready not dropped on write");
  chk_pll_restart: assert property (
    wr_pll && bus_in.wdata[13:8] != 6'h0 |=> !lock_r ##1 !lock_r)
    else $error("lock set too early");
  chk_osc_bypass: assert property (
    wr_osc && bus_in.wdata[`CSRI_OSC_BYP_BIT] |=> flags[`CSRI_BIT_MOSC])
    else $error("bypass did not mark oscillator stable");
  chk_div_edge: assert property (
    cfg_r[0].prescaler_select != 3'h0 && $changed(clk_q[0]) && $stable(cfg_r[0]) |-> $past(|rise))
    else $error("master divider toggled without source edge");
  chk_pck_rsvd: assert property (
    cfg_r[1].clock_source_select == `CSRI_SRC_RSVD && $stable(cfg_r[1]) |-> $stable(clk_q[1]))
    else $error("reserved source still clocks");

  cov_irq: cover property ($rose(irq_out));
  cov_lock: cover property ($rose(lock_r));
  cov_osc: cover property ($rose(flags[`CSRI_BIT_MOSC]));
  cov_pck_ready: cover property ($rose(rdy_r[1]));
endmodule

//--- rtl/csri_params.svh
`ifndef CSRI_PARAMS_SVH
`define CSRI_PARAMS_SVH

// Register byte offsets
`define CSRI_OFF_MCK_CFG 8'h00
`define CSRI_OFF_PCK0_CFG 8'h04
`define CSRI_OFF_PCK1_CFG 8'h08
`define CSRI_OFF_PCK2_CFG 8'h0c
`define CSRI_OFF_INT_SET 8'h10
`define CSRI_OFF_INT_CLR 8'h14
`define CSRI_OFF_STATUS 8'h18
`define CSRI_OFF_INT_MASK 8'h1c
`define CSRI_OFF_EVENT 8'h20
`define CSRI_OFF_OSC_CFG 8'h24
`define CSRI_OFF_PLL_CFG 8'h28

// Flag bit positions, shared by status, event and mask registers
`define CSRI_BIT_MOSC 0
`define CSRI_BIT_LOCK 2
`define CSRI_BIT_MCK 3
`define CSRI_BIT_PCK0 8
`define CSRI_FLAG_MASK 11'h70d
// Flag levels right after reset: all clocks ready, oscillator off, no lock
`define CSRI_FLAG_RST 11'h708

// Clock configuration encodings
`define CSRI_SRC_RSVD 2'h2
`define CSRI_DIV_RSVD 3'h7

// Oscillator and PLL configuration fields
`define CSRI_OSC_EN_BIT 0
`define CSRI_OSC_BYP_BIT 1
`define CSRI_OSC_CNT_LSB 8
`define CSRI_PLL_CNT_LSB 8

// Settle time after a clock config write, in mclk cycles
`define CSRI_SETTLE_CYC 16

`endif

//--- rtl/csri_pkg.sv
package csri_pkg;

  // Source and prescaler selection of one clock
  typedef struct packed {
    logic [2:0] prescaler_select;
    logic [1:0] clock_source_select;
  } csri_clk_cfg_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } csri_bus_req_t;

endpackage

//--- tb/csri_tb.sv
`timescale 1ns/1ps
`include "csri_params.svh"
module testbench;
  import csri_pkg::*;
  localparam int SETTLE = 4;
  logic mclk_in = 1'b0;
  logic arst_n_in = 1'b0;
  csri_bus_req_t bus = '0;
  logic [2:0] src_clk_in = 3'h0;
  logic [31:0] rdata_out;
  logic mck_out;
  logic [2:0] prog_clk_out;
  logic irq_out;
  logic [3:0] cnt = 4'h0;
  logic [1:0] srcs [3] = '{2'h0, 2'h1, 2'h3};
  logic [31:0] rv;
  int num_errors = 0;
  int total_checks = 0;

  csri_top #(.SETTLE_CYC(SETTLE)) dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .bus_in(bus),
    .rdata_out(rdata_out), .src_clk_in(src_clk_in), .mck_out(mck_out), .prog_clk_out(prog_clk_out),
    .irq_out(irq_out));

  // 50 MHz system clock
  initial begin
    forever #10 mclk_in = ~mclk_in;
  end

  // Sources slow, main, PLL at periods 16, 8, 4; four is the shortest the synchroniser passes
  always @(posedge mclk_in) begin
    cnt <= cnt + 4'h1;
    src_clk_in <= {cnt[1], cnt[2], cnt[3]};
  end

  // Period of a source in system cycles
  function automatic int src_per(input logic [1:0] s);
    return (s == 2'h0) ? 16 : (s == 2'h1) ? 8 : 4;
  endfunction

  function automatic logic clk_of(input int i);
    return (i == 3) ? mck_out : prog_clk_out[i];
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_in);
    bus.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_in);
    bus.rd <= 1'b0;
    #1 d = rdata_out;
  endtask

  // Polls one status bit, bounded so a stuck flag ends the run
  task automatic wait_flag(input int b, input logic v, input int lim);
    for (int i = 0; i < lim; i++) begin
      rd(`CSRI_OFF_STATUS, rv);
      if (rv[b] === v) return;
    end
    num_errors++;
    $display("MISMATCH status bit %0d expected %b seen timeout", b, v);
    results();
  endtask

  // Cycles between two rising edges of a generated clock, -1 if none
  task automatic meas(input int i, output int p);
    logic pv;
    int r;
    r = 0;
    p = 0;
    pv = clk_of(i);
    for (int n = 0; n < 3000; n++) begin
      @(posedge mclk_in);
      #1;
      if (r == 1) p++;
      if (clk_of(i) && !pv) r++;
      pv = clk_of(i);
      if (r == 2) return;
    end
    p = -1;
  endtask

  initial begin
    logic [31:0] w;
    logic [31:0] m;
    logic [1:0] s;
    logic [2:0] p;
    logic [7:0] off;
    int per;
    m = 32'h0;
    void'($urandom(67584));
    repeat (16) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    // Reset state of flags and mask
    rd(`CSRI_OFF_STATUS, rv);
    chk("status", rv, 32'h708);
    rd(`CSRI_OFF_INT_MASK, rv);
    chk("mask", rv, 32'h0);
    chk("irq", {31'h0, irq_out}, 32'h0);
    $display("test reset done");
    // Random set and clear of mask bits, write-only places read back zero
    for (int k = 0; k < 12; k++) begin
      w = $urandom;
      if (k % 2 == 0 || w[31]) begin
        wr(`CSRI_OFF_INT_SET, w);
        m = m | (w & {21'h0, `CSRI_FLAG_MASK});
      end else begin
        wr(`CSRI_OFF_INT_CLR, w);
        m = m & ~w;
      end
      rd(`CSRI_OFF_INT_MASK, rv);
      chk("mask", rv, m);
    end
    rd(`CSRI_OFF_INT_SET, rv);
    chk("enable set read", rv, 32'h0);
    rd(`CSRI_OFF_INT_CLR, rv);
    chk("enable clear read", rv, 32'h0);
    rd(8'h3c, rv);
    chk("unmapped read", rv, 32'h0);
    wr(`CSRI_OFF_INT_CLR, 32'hffffffff);
    $display("test mask done");
    // Every clock, every valid source code, slowest divide first then random
    for (int i = 0; i < 4; i++) begin
      off = (i == 3) ? `CSRI_OFF_MCK_CFG : 8'(4 + 4 * i);
      for (int k = 0; k < 3; k++) begin
        s = srcs[(k + i) % 3];
        p = (k == 0) ? 3'h6 : 3'($urandom % 7);
        wr(off, {27'h0, p, s});
        rd(`CSRI_OFF_STATUS, rv);
        chk("ready after write", {31'h0, rv[(i == 3) ? 3 : 8 + i]}, 32'h0);
        wait_flag((i == 3) ? 3 : 8 + i, 1'b1, 10);
        rd(off, rv);
        chk("config", rv[4:0], {27'h0, p, s});
        meas(i, per);
        chk("period", per, src_per(s) << p);
      end
    end
    // Reserved source and prescaler codes hold ready low
    wr(`CSRI_OFF_PCK1_CFG, {27'h0, 3'h0, `CSRI_SRC_RSVD});
    wr(`CSRI_OFF_PCK2_CFG, {27'h0, `CSRI_DIV_RSVD, 2'h0});
    for (int k = 0; k < 8; k++) begin
      rd(`CSRI_OFF_STATUS, rv);
      chk("reserved ready", rv[10:9], 32'h0);
    end
    $display("test clocks done");
    // Oscillator bypass, interrupt follows mask
    wr(`CSRI_OFF_OSC_CFG, 32'h2);
    wait_flag(0, 1'b1, 5);
    chk("irq masked", {31'h0, irq_out}, 32'h0);
    wr(`CSRI_OFF_INT_SET, 32'h1);
    @(posedge mclk_in);
    #1 chk("irq", {31'h0, irq_out}, 32'h1);
    wr(`CSRI_OFF_INT_CLR, 32'h1);
    @(posedge mclk_in);
    #1 chk("irq", {31'h0, irq_out}, 32'h0);
    wr(`CSRI_OFF_OSC_CFG, 32'h0);
    wait_flag(0, 1'b0, 5);
    // Start-up count of one: eight slow periods
    wr(`CSRI_OFF_OSC_CFG, 32'h101);
    rd(`CSRI_OFF_STATUS, rv);
    chk("osc early", {31'h0, rv[0]}, 32'h0);
    wait_flag(0, 1'b1, 100);
    // Clear all events; lock after three slow periods leaves only its own event
    wr(`CSRI_OFF_EVENT, 32'h7ff);
    rd(`CSRI_OFF_EVENT, rv);
    chk("events cleared", rv, 32'h0);
    wr(`CSRI_OFF_PLL_CFG, 32'h300);
    rd(`CSRI_OFF_STATUS, rv);
    chk("lock early", {31'h0, rv[2]}, 32'h0);
    wait_flag(2, 1'b1, 40);
    rd(`CSRI_OFF_EVENT, rv);
    chk("lock event", rv, 32'h4);
    $display("test flags done");
    // Mid-run reset drops mask, interrupt and events and restores the ready flags
    wr(`CSRI_OFF_INT_SET, 32'h70d);
    @(posedge mclk_in);
    #1 chk("irq before reset", {31'h0, irq_out}, 32'h1);
    @(posedge mclk_in);
    arst_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    chk("irq in reset", {31'h0, irq_out}, 32'h0);
    rd(`CSRI_OFF_INT_MASK, rv);
    chk("mask after reset", rv, 32'h0);
    rd(`CSRI_OFF_STATUS, rv);
    chk("status after reset", rv, 32'h708);
    rd(`CSRI_OFF_EVENT, rv);
    chk("events after reset", rv, 32'h0);
    $display("test second reset done");
    results();
  end
endmodule
